// *** inc/odtr_cfg.svh ***
`ifndef ODTR_CFG_SVH
`define ODTR_CFG_SVH

// Data path and time widths, field length and label limit
`define ODTR_TS_W 64
`define ODTR_OFS_W 8
`define ODTR_FIELD_BYTES 4'h8
`define ODTR_MAX_LABELS 3'h4
// Byte offsets of fields in a plain Y.1731 PDU (after the header start)
`define ODTR_OPC_POS 8'h0F
`define ODTR_TXF_POS 8'h12
`define ODTR_RXF_POS 8'h1A
`define ODTR_TXB_POS 8'h22
`define ODTR_RXB_POS 8'h2A
`define ODTR_ETYPE_HI 8'h0C
`define ODTR_MPLS_HDR 8'h04
// Codes
`define ODTR_ETYPE_OAM 16'h8902
`define ODTR_ETYPE_MPLS 16'h8847
`define ODTR_OPC_DMM 8'h2F
`define ODTR_OPC_DMR 8'h2E
// Time counter
`define ODTR_NS_STEP 64'h0000_0000_0000_000A
`define ODTR_ONE_NS 64'h0000_0000_0000_0001
`define ODTR_SEC_CYCLES 32'h05F5_E0FF
// Distance from the last data byte to the end mark in the delay line
`define ODTR_FCS_AHEAD 6'h04
// Delay line depth in bytes
`define ODTR_DLY 64
`define ODTR_DLY_W 6

`endif

// *** inc/odtr_pkg.sv ***
package odtr_pkg;
    typedef logic [63:0] odtr_time_t;
    typedef logic [7:0] odtr_byte_t;
    typedef enum {ODTR_ING, ODTR_EGR} odtr_dir_e;
    typedef enum {ODTR_IDLE, ODTR_HDR, ODTR_BODY, ODTR_FCS} odtr_state_e;
endpackage

// *** inc/odtr_if.sv ***
`timescale 1ns/1ns
interface odtr_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    logic sof;
    logic eof;
    modport dev (input valid, input data, input sof, input eof, output ready);
    modport mac (output valid, output data, output sof, output eof, input ready);
endinterface

// *** verilog/odtr_dev.sv ***
`timescale 1ns/1ns
`include "odtr_cfg.svh"
// Notes on behaviour
// [R1] Ingress DMM/DMR: write receive field, 8 bytes
// [R2] Write time at offset, then recompute FCS
// [R3] Ingress DMM forward rx = raw minus latency
// [R4] Ingress DMR backward rx = raw minus latency
// [R5] Egress DMM: write forward transmit field
// [R6] Egress DMR: write backward transmit field
// [R7] Egress DMM forward tx = raw plus latency
// [R8] Egress DMR backward tx = raw plus latency
// [R9] Initiator sends DMM with empty transmit time
// [R10] Responder swaps MACs, changes opcode only
// [R11] Replies may carry peer rx/tx times
// [R12] MPLS-TP frames too, up to 4 labels
// [R13] Preload becomes time at sync rising edge
// [R14] Software plus/minus one nanosecond adjust
// [R15] Save strobe captures time for software
// [R16] Programmable cycle count for 1 ns correction
// [R17] Pulse output may chain to next load/save
// [R18] Unmatched frames pass unchanged
// [R19] Load/save triggered by dedicated input pin
// [R20] Non-local delay frames never rewritten
// [R21] Delay line covers analysis latency
module odtr_dev (
    input wire logic clk,
    input wire logic srst,
    odtr_if.dev rx,
    odtr_if.mac tx,
    input wire logic dir_egress,
    input wire logic [47:0] local_mac,
    input wire logic [`ODTR_TS_W-1:0] latency_ofs,
    input wire logic [`ODTR_TS_W-1:0] preload_time,
    input wire logic load_arm,
    input wire logic save_arm,
    input wire logic load_save_pin,
    input wire logic adj_plus,
    input wire logic adj_minus,
    input wire logic [31:0] rate_period,
    input wire logic rate_neg,
    output logic [`ODTR_TS_W-1:0] saved_time,
    output logic [`ODTR_TS_W-1:0] cur_time,
    output logic pps_out
);
    import odtr_pkg::*;

    typedef struct packed {
        logic [1:0] pin_sync;
        logic pin_last;
        odtr_time_t tod;
        odtr_time_t saved;
        logic [31:0] rate_cnt;
        logic [31:0] sec_cnt;
        logic pps;
        logic [7:0] pos;
        logic [15:0] etype;
        logic [2:0] labels;
        logic bos;
        logic [7:0] pdu_base;
        logic [47:0] da;
        logic [47:0] sa;
        logic hit;
        logic [7:0] wr_ofs;
        odtr_time_t stamp;
        odtr_time_t raw;
        logic [31:0] crc;
        logic [7:0] opos;
        logic [1:0] bcnt;
        logic [3:0] fcs_left;
        logic [`ODTR_DLY_W:0] fill;
    } odtr_s;

    odtr_s s_r, s_nxt;
    logic [9:0] line_r [0:`ODTR_DLY-1];
    logic [`ODTR_DLY_W-1:0] wp_r, rp_r;
    logic [9:0] head;
    logic push, pop, out_v;
    logic [7:0] out_byte;
    logic [2:0] k;
    logic [7:0] rel;
    logic [7:0] opc;
    logic local_dst, local_src;

    function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hEDB8_8320) : (r >> 1);
        end
        return r;
    endfunction

    // Delay line with ready/valid on both sides; a stall holds the words
    assign push = rx.valid && rx.ready;
    assign rx.ready = (s_r.fill < (`ODTR_DLY_W+1)'(`ODTR_DLY)) && !srst;
    assign out_v = (s_r.fill == (`ODTR_DLY_W+1)'(`ODTR_DLY)) || (s_r.fill != '0 && !rx.valid); // R21
    assign pop = out_v && tx.ready;
    assign head = line_r[rp_r];
    assign tx.valid = out_v;
    assign tx.sof = head[8];
    assign tx.eof = head[9];
    assign tx.data = out_byte;

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                line_r[wp_r] <= {rx.eof, rx.sof, rx.data};
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    always_comb begin
        rel = s_r.opos - s_r.wr_ofs;
        k = rel[2:0];
        out_byte = head[7:0];
        // Time stamp replaces 8 bytes at the offset
        if (s_r.hit && s_r.opos >= s_r.wr_ofs && rel < 8'(`ODTR_FIELD_BYTES)) begin // R1 R2 R5 R6
            out_byte = s_r.stamp[63 - 8*k -: 8]; // R2
        end
        // New FCS in the last four bytes
        if (s_r.hit && s_r.fcs_left != 4'h0) begin // R2
            out_byte = ~s_r.crc[8*s_r.bcnt +: 8];
        end
    end

    always_comb begin
        s_nxt = s_r;
        opc = rx.data;
        local_dst = (s_r.da == local_mac);
        local_src = (s_r.sa == local_mac);
        // Time counter with rate correction
        s_nxt.pin_sync = {s_r.pin_sync[0], load_save_pin};
        s_nxt.pin_last = s_r.pin_sync[1];
        s_nxt.tod = s_r.tod + `ODTR_NS_STEP;
        if (rate_period != 32'h0000_0000) begin // R16
            s_nxt.rate_cnt = s_r.rate_cnt + 32'h0000_0001;
            if (s_r.rate_cnt >= rate_period - 32'h0000_0001) begin
                s_nxt.rate_cnt = '0;
                s_nxt.tod = rate_neg ? s_nxt.tod - `ODTR_ONE_NS : s_nxt.tod + `ODTR_ONE_NS;
            end
        end
        if (adj_plus) begin // R14
            s_nxt.tod = s_nxt.tod + `ODTR_ONE_NS;
        end else if (adj_minus) begin
            s_nxt.tod = s_nxt.tod - `ODTR_ONE_NS;
        end
        if (s_r.pin_sync[1] && !s_r.pin_last) begin // R19
            if (load_arm) begin
                s_nxt.tod = preload_time; // R13
            end
            if (save_arm) begin
                s_nxt.saved = s_r.tod; // R15
            end
        end
        // One pulse per second, can feed a neighbour's load/save pin
        s_nxt.sec_cnt = s_r.sec_cnt + 32'h0000_0001; // R17
        s_nxt.pps = 1'b0;
        if (s_r.sec_cnt == `ODTR_SEC_CYCLES) begin
            s_nxt.sec_cnt = '0;
            s_nxt.pps = 1'b1;
        end
        // Analyzer on the input side
        if (push) begin
            if (rx.sof) begin
                s_nxt.pos = 8'h01;
                s_nxt.raw = s_r.tod;
                s_nxt.labels = '0;
                s_nxt.bos = 1'b0;
                s_nxt.pdu_base = `ODTR_ETYPE_HI + 8'h02;
                s_nxt.hit = 1'b0;
                s_nxt.da = {rx.data, 40'h0};
            end else begin
                if (s_r.pos != 8'hFF) begin
                    s_nxt.pos = s_r.pos + 8'h01;
                end
                if (s_r.pos < 8'h06) begin
                    s_nxt.da[47 - 8*s_r.pos[2:0] -: 8] = rx.data;
                end else if (s_r.pos < 8'h0C) begin
                    s_nxt.sa[95 - 8*s_r.pos[3:0] -: 8] = rx.data;
                end
                if (s_r.pos == `ODTR_ETYPE_HI || s_r.pos == `ODTR_ETYPE_HI + 8'h01) begin
                    s_nxt.etype = {s_r.etype[7:0], rx.data};
                end
                // Bottom-of-stack bit of the label just counted
                if (s_r.labels != 3'h0 && s_r.pos == s_r.pdu_base - 8'h02) begin
                    s_nxt.bos = rx.data[0]; // R12
                end
                // MPLS labels push the PDU further out
                if (s_r.pos == s_r.pdu_base && s_r.etype == `ODTR_ETYPE_MPLS
                    && !s_r.bos && s_r.labels < `ODTR_MAX_LABELS) begin // R12
                    s_nxt.labels = s_r.labels + 3'h1;
                    s_nxt.pdu_base = s_r.pdu_base + `ODTR_MPLS_HDR;
                end
                if (s_r.pos == s_r.pdu_base + `ODTR_OPC_POS - `ODTR_ETYPE_HI - 8'h02
                    && (s_r.etype == `ODTR_ETYPE_OAM || s_r.labels != 3'h0)) begin // R18
                    if (opc == `ODTR_OPC_DMM || opc == `ODTR_OPC_DMR) begin
                        if (!dir_egress && local_dst) begin // R20
                            s_nxt.hit = 1'b1;
                            s_nxt.stamp = s_r.raw - latency_ofs; // R3 R4
                            s_nxt.wr_ofs = s_r.pdu_base - 8'h0E +
                                ((opc == `ODTR_OPC_DMM) ? `ODTR_RXF_POS : `ODTR_RXB_POS); // R1
                        end else if (dir_egress && local_src) begin // R20
                            s_nxt.hit = 1'b1;
                            s_nxt.stamp = s_r.raw + latency_ofs; // R7 R8
                            s_nxt.wr_ofs = s_r.pdu_base - 8'h0E +
                                ((opc == `ODTR_OPC_DMM) ? `ODTR_TXF_POS : `ODTR_TXB_POS); // R5 R6
                        end
                    end
                end
            end
        end
        // Rewriter on the output side
        if (pop) begin
            s_nxt.opos = head[8] ? 8'h01 : (s_r.opos == 8'hFF ? s_r.opos : s_r.opos + 8'h01);
            if (head[8]) begin
                s_nxt.opos = 8'h01;
                s_nxt.crc = crc8(32'hFFFF_FFFF, out_byte);
                s_nxt.fcs_left = 4'h0;
            end else if (s_r.fcs_left != 4'h0) begin
                s_nxt.fcs_left = s_r.fcs_left - 4'h1;
                s_nxt.bcnt = s_r.bcnt + 2'h1;
                if (s_r.fcs_left == 4'h1) begin
                    s_nxt.hit = 1'b0; // R18
                end
            end else begin
                s_nxt.crc = crc8(s_r.crc, out_byte);
            end
            // FCS is the last four bytes; start regeneration when the last data byte leaves
            if (s_r.hit && line_r[rp_r + `ODTR_FCS_AHEAD][9] && s_r.fcs_left == 4'h0 && !head[8]) begin
                s_nxt.fcs_left = 4'h4;
                s_nxt.bcnt = 2'h0;
                s_nxt.crc = crc8(s_r.crc, out_byte);
            end
        end
        s_nxt.fill = s_r.fill + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign saved_time = s_r.saved;
    assign cur_time = s_r.tod;
    assign pps_out = s_r.pps;
endmodule

// *** verilog/odtr_mac.sv ***
`timescale 1ns/1ns
`include "odtr_cfg.svh"
module odtr_mac (
    input wire logic clk,
    input wire logic srst,
    odtr_if.mac tx,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    input wire logic in_sof,
    input wire logic in_eof
);
    import odtr_pkg::*;

    typedef struct packed {
        logic [1:0] cnt;
        logic [1:0][9:0] buf_q;
        logic rd;
        logic wr;
    } odtr_mac_s;

    odtr_mac_s s_r, s_nxt;
    logic push, pop;

    // Two-entry buffer toward the device; user builds frames per R9 R10 R11
    assign in_ready = (s_r.cnt != 2'h2);
    assign push = in_valid && in_ready;
    assign tx.valid = (s_r.cnt != 2'h0);
    assign pop = tx.valid && tx.ready;
    assign tx.data = s_r.buf_q[s_r.rd][7:0];
    assign tx.sof = s_r.buf_q[s_r.rd][8];
    assign tx.eof = s_r.buf_q[s_r.rd][9];

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.buf_q[s_r.wr] = {in_eof, in_sof, in_data};
            s_nxt.wr = ~s_r.wr;
        end
        if (pop) begin
            s_nxt.rd = ~s_r.rd;
        end
        s_nxt.cnt = s_r.cnt + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// *** tb/odtr_asserts.sv ***
`timescale 1ns/1ns
module odtr_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic valid,
    input wire logic ready,
    input wire logic [7:0] data,
    input wire logic sof,
    input wire logic eof
);
    logic in_frm_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            in_frm_r <= 1'b0;
        end else if (valid && ready) begin
            in_frm_r <= !eof;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_vhold; valid && !ready |=> valid; endproperty
    property p_dhold; valid && !ready |=> $stable(data); endproperty
    property p_mhold; valid && !ready |=> $stable({sof, eof}); endproperty
    property p_rst; disable iff (1'b0) srst ##1 srst |-> !valid && !ready; endproperty
    property p_first; valid && !in_frm_r |-> sof; endproperty
    property p_once; valid && in_frm_r |-> !sof; endproperty
    property p_wake; $fell(srst) |-> ##[0:4] ready; endproperty
    property p_nobig; valid |-> !(sof && eof); endproperty
    a_vhold: assert property (p_vhold) else $error("valid dropped");
    a_dhold: assert property (p_dhold) else $error("data moved");
    a_mhold: assert property (p_mhold) else $error("marks moved");
    a_rst: assert property (p_rst) else $error("busy in reset");
    a_first: assert property (p_first) else $error("no start mark");
    a_once: assert property (p_once) else $error("extra start mark");
    a_wake: assert property (p_wake) else $error("ready late");
    a_nobig: assert property (p_nobig) else $error("bad marks");
    c_stall: cover property (valid && !ready);
    c_end: cover property (valid && ready && eof);
    c_full: cover property (!ready ##1 !ready);
endmodule

// *** tb/oam_delay_timestamp_rewrite_tb.sv ***
`timescale 1ns/1ns
`include "odtr_cfg.svh"
module oam_delay_timestamp_rewrite_tb;
    import odtr_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic in_valid = 1'b0, in_ready, in_sof = 1'b0, in_eof = 1'b0;
    logic [7:0] in_data = 8'h00;
    logic dir = 1'b0, l_arm = 1'b0, s_arm = 1'b0, pin = 1'b0, adp = 1'b0, adm = 1'b0, rneg = 1'b0;
    logic [47:0] mac;
    logic [63:0] lat, a, saved, cur;
    logic [63:0] pre = 64'h0000_0100_0000_0000;
    logic [31:0] rper = 32'h0000_0000, lfsr = 32'hd582;
    odtr_byte_t fr [80];
    odtr_byte_t ob [80];
    int oc, err_count, n_checks, cyc, t_sof, c1, c2;
    odtr_if ifa ();
    odtr_if ifb ();
    always #5 clk = ~clk;
    odtr_mac odtr_mac_i (.clk(clk), .srst(srst), .tx(ifa), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .in_sof(in_sof), .in_eof(in_eof));
    odtr_dev odtr_dev_i (.clk(clk), .srst(srst), .rx(ifa), .tx(ifb), .dir_egress(dir), .local_mac(mac),
        .latency_ofs(lat), .preload_time(pre), .load_arm(l_arm), .save_arm(s_arm), .load_save_pin(pin),
        .adj_plus(adp), .adj_minus(adm), .rate_period(rper), .rate_neg(rneg), .saved_time(saved),
        .cur_time(cur), .pps_out());
    odtr_asserts odtr_asserts_i (.clk(clk), .srst(srst), .valid(ifa.valid), .ready(ifa.ready),
        .data(ifa.data), .sof(ifa.sof), .eof(ifa.eof));
    function automatic logic [31:0] rnd();
        lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h8020_0003 : lfsr >> 1;
        return lfsr;
    endfunction
    function automatic logic [31:0] crc(input odtr_byte_t b [80]);
        logic [31:0] c;
        c = 32'hffff_ffff;
        for (int i = 0; i < 76; i++) begin
            c = c ^ {24'h0, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
        end
        return ~c;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial ifb.ready = 1'b0;
    always @(posedge clk) ifb.ready <= !srst && (rnd() % 4 != 0);
    always @(posedge clk) cyc <= srst ? 0 : cyc + 1;
    always @(negedge clk) begin
        if (!srst && ifa.valid && ifa.ready && ifa.sof) t_sof = cyc + 1;
        if (!srst && ifb.valid && ifb.ready && oc < 80) begin
            chk(ifb.sof, oc == 0);
            chk(ifb.eof, oc == 79);
            ob[oc] = ifb.data;
            oc = oc + 1;
        end
    end
    task automatic send();
        logic ok;
        for (int i = 0; i < 80; i++) begin
            in_valid <= 1'b1;
            in_data <= fr[i];
            in_sof <= (i == 0);
            in_eof <= (i == 79);
            ok = 1'b0;
            while (ok !== 1'b1) begin
                @(negedge clk);
                ok = in_ready;
                @(posedge clk);
            end
            if (rnd() % 8 == 0) begin
                in_valid <= 1'b0;
                @(posedge clk);
            end
        end
        in_valid <= 1'b0;
    endtask
    task automatic frame(input int kind, input int nl);
        logic [63:0] got, expv;
        logic [47:0] da, sa;
        int o, n;
        logic wr, dmr, d;
        wr = (kind < 4);
        dmr = (kind == 1 || kind == 3);
        d = (kind < 2) ? 1'b0 : (kind < 4) ? 1'b1 : rnd() % 2;
        dir <= d;
        da = ((wr && !d) || kind == 5) ? mac : mac ^ 48'h1;
        sa = ((wr && d) || kind == 5) ? mac : mac ^ 48'h2;
        for (int i = 0; i < 76; i++) fr[i] = odtr_byte_t'(rnd());
        for (int i = 18 + 4 * nl; i < 50 + 4 * nl; i++) fr[i] = 8'h00;
        for (int i = 0; i < 6; i++) fr[i] = da[47 - 8 * i -: 8];
        for (int i = 0; i < 6; i++) fr[6 + i] = sa[47 - 8 * i -: 8];
        {fr[12], fr[13]} = (kind == 5) ? 16'h0800 : (nl > 0) ? `ODTR_ETYPE_MPLS : `ODTR_ETYPE_OAM;
        for (int j = 0; j < nl; j++) fr[16 + 4 * j] = (j == nl - 1) ? 8'h01 : 8'h00;
        fr[15 + 4 * nl] = dmr ? `ODTR_OPC_DMR : `ODTR_OPC_DMM;
        {fr[79], fr[78], fr[77], fr[76]} = crc(fr);
        o = (d ? (dmr ? 34 : 18) : (dmr ? 42 : 26)) + 4 * nl;
        oc = 0;
        send();
        n = 0;
        while (oc < 80 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk(oc, 80);
        for (int i = 0; i < 76; i++) if (!wr || i < o || i >= o + 8) chk(ob[i], fr[i]);
        for (int k = 0; k < 8; k++) got = {got[55:0], ob[o + k]};
        expv = d ? 64'(10 * t_sof) + lat : 64'(10 * t_sof) - lat;
        if (wr) chk((got - expv + 64'd40) <= 64'd80, 1'b1);
        chk({ob[79], ob[78], ob[77], ob[76]}, crc(ob));
    endtask
    initial begin
        mac = 48'(rnd()) ^ {rnd(), 16'h0000};
        lat = {32'h0000_0000, rnd()};
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 30; k++) frame(k % 6, k % 5);
        l_arm <= 1'b1;
        pin <= 1'b1;
        c1 = cyc;
        repeat (3) @(posedge clk);
        pin <= 1'b0;
        repeat (6) @(posedge clk);
        l_arm <= 1'b0;
        s_arm <= 1'b1;
        #1 chk(cur - pre <= 64'(10 * (cyc - c1)), 1'b1);
        repeat (20) @(posedge clk);
        pin <= 1'b1;
        c2 = cyc;
        repeat (3) @(posedge clk);
        pin <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(saved - pre - 64'(10 * (c2 - c1)) + 64'd10 <= 64'd20, 1'b1);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            adp <= (s == 0);
            adm <= (s == 1);
            #1 a = cur;
            @(posedge clk);
            adp <= 1'b0;
            adm <= 1'b0;
            repeat (4) @(posedge clk);
            #1 chk(cur - a, s ? 64'd49 : 64'd51);
        end
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            rper <= 32'h0000_0004;
            rneg <= (s == 1);
            #1 a = cur;
            repeat (40) @(posedge clk);
            rper <= 32'h0000_0000;
            #1 chk(cur - a - (s ? 64'd390 : 64'd410) + 64'd1 <= 64'd2, 1'b1);
        end
        conclude();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule
